// ==== rtl/csc_sequencer.v ====
// Purpose: sample and convert sequencing under the converter clock trigger
// Assumes: config fields stable while enabled; enable low acts as reset
// Notes: a manual trigger (clearing the sample bit) is also honoured
`timescale 1ns/10ps
`default_nettype none
`include "csc_regs.vh"
module csc_sequencer (
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  output reg irq_o,
  output reg sampling_o,
  output reg converting_o,
  output reg [1:0] channel_o,
  output reg [3:0] hold_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SAMPLE_CONTROL_BIT = 2'h1;
  localparam ST_CONV = 2'h2;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg enable_q;
  reg [2:0] trig_q;
  reg sim_q;
  reg auto_q;
  reg sample_control_bit_q;
  reg done_q;
  reg [1:0] chcnt_q;
  reg [4:0] stime_q;
  reg [5:0] cdiv_q;
  reg [1:0] ch_q;
  reg [1:0] ch_d;
  reg [`CSC_IRQ_W-1:0] stat_q;
  reg [`CSC_IRQ_W-1:0] mask_q;
  reg [15:0] seq_cnt_q;
  wire run = ce_i && enable_q;
  wire tick;
  wire sample_control_bit_hit;
  wire sample_control_bit_busy;
  wire conv_hit;
  wire conv_busy;
  reg sample_control_bit_start;
  reg conv_start;
  reg clr_sample_control_bit;
  reg set_done;
  reg seq_end;
  wire [1:0] last_ch = (chcnt_q == 2'h0) ? 2'h0 : ((chcnt_q == 2'h1) ? 2'h1 : 2'h3);
  wire multi = (chcnt_q != 2'h0);
  wire seq_mode = multi && !sim_q;
  wire wr_ctrl1 = wr_i && (addr_i == `CSC_OFF_CTRL1);
  wire sw_sample_control_bit_set = wr_ctrl1 && wdata_i[`CSC_B_SAMPLE] && !sample_control_bit_q;
  wire sw_sample_control_bit_clr = wr_ctrl1 && !wdata_i[`CSC_B_SAMPLE] && sample_control_bit_q;
  wire clocked = (trig_q == `CSC_TRIG_CLOCKED);
  // end of sampling: the period counter when clocked, software clear when manual
  wire sample_control_bit_end = clocked ? sample_control_bit_hit : ((trig_q == `CSC_TRIG_MANUAL) && sw_sample_control_bit_clr);
  // period strobe restarts with each phase so counts are whole periods
  csc_tick_div u_div (
    .clk_i(clk_i),
    .srst_i(srst_i || !enable_q),
    .ce_i(ce_i),
    .clr_i(sample_control_bit_start || conv_start),
    .div_i(cdiv_q),
    .tick_o(tick)
  );
  csc_period_cnt u_sample_control_bit (
    .clk_i(clk_i),
    .srst_i(srst_i || !enable_q),
    .ce_i(ce_i && clocked),
    .start_i(sample_control_bit_start),
    .tick_i(tick),
    .target_i(stime_q),
    .hit_o(sample_control_bit_hit),
    .busy_o(sample_control_bit_busy)
  );
  csc_period_cnt u_conv (
    .clk_i(clk_i),
    .srst_i(srst_i || !enable_q),
    .ce_i(ce_i),
    .start_i(conv_start),
    .tick_i(tick),
    .target_i(`CSC_CONV_PERIODS),
    .hit_o(conv_hit),
    .busy_o(conv_busy)
  );
  always @* begin
    state_d = state_q;
    ch_d = ch_q;
    sample_control_bit_start = 1'b0;
    conv_start = 1'b0;
    clr_sample_control_bit = 1'b0;
    set_done = 1'b0;
    seq_end = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // auto sampling starts by itself once enabled; manual waits for the sample bit
        if (sw_sample_control_bit_set || auto_q) begin
          state_d = ST_SAMPLE_CONTROL_BIT;
          ch_d = 2'h0;
          sample_control_bit_start = 1'b1;
        end
      end
      ST_SAMPLE_CONTROL_BIT: begin
        if (sample_control_bit_end) begin
          state_d = ST_CONV;
          conv_start = 1'b1;
          clr_sample_control_bit = 1'b1;
        end
      end
      ST_CONV: begin
        if (conv_hit) begin
          if (ch_q != last_ch) begin
            ch_d = ch_q + 2'h1;
            if (seq_mode) begin
              state_d = ST_SAMPLE_CONTROL_BIT;
              sample_control_bit_start = 1'b1;
            end else begin
              conv_start = 1'b1;
            end
          end else begin
            set_done = 1'b1;
            seq_end = 1'b1;
            ch_d = 2'h0;
            if (auto_q) begin
              state_d = ST_SAMPLE_CONTROL_BIT;
              sample_control_bit_start = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end
  always @(posedge clk_i) begin
    if (srst_i) begin
      enable_q <= 1'b0;
      trig_q <= 3'h0;
      sim_q <= 1'b0;
      auto_q <= 1'b0;
      chcnt_q <= 2'h0;
      stime_q <= 5'h00;
      cdiv_q <= 6'h00;
      mask_q <= {`CSC_IRQ_W{1'b0}};
    end else if (ce_i && wr_i) begin
      case (addr_i)
        `CSC_OFF_CTRL1: begin
          enable_q <= wdata_i[`CSC_B_ENABLE];
          trig_q <= wdata_i[`CSC_B_TRIG_HI:`CSC_B_TRIG_LO];
          sim_q <= wdata_i[`CSC_B_SIMSEL];
          auto_q <= wdata_i[`CSC_B_AUTO];
        end
        `CSC_OFF_CTRL2: chcnt_q <= wdata_i[`CSC_B_CHCNT_HI:`CSC_B_CHCNT_LO];
        `CSC_OFF_CTRL3: begin
          stime_q <= wdata_i[`CSC_B_STIME_HI:`CSC_B_STIME_LO];
          cdiv_q <= wdata_i[`CSC_B_CDIV_HI:`CSC_B_CDIV_LO];
        end
        `CSC_OFF_MASK: mask_q <= wdata_i[`CSC_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end
  always @(posedge clk_i) begin
    if (srst_i || !enable_q) begin
      state_q <= ST_IDLE;
      ch_q <= 2'h0;
      sample_control_bit_q <= 1'b0;
      done_q <= 1'b0;
      seq_cnt_q <= 16'h0000;
    end else if (run) begin
      state_q <= state_d;
      ch_q <= ch_d;
      // hardware set wins over a software write in the same cycle
      if (sample_control_bit_start)
        sample_control_bit_q <= 1'b1;
      else if (clr_sample_control_bit)
        sample_control_bit_q <= 1'b0;
      else if (wr_ctrl1)
        sample_control_bit_q <= wdata_i[`CSC_B_SAMPLE];
      if (set_done)
        done_q <= 1'b1;
      else if (sample_control_bit_start || (wr_ctrl1 && !wdata_i[`CSC_B_DONE]))
        done_q <= 1'b0;
      if (seq_end)
        seq_cnt_q <= seq_cnt_q + 16'h0001;
    end
  end
  // status: set wins over write-one-to-clear
  always @(posedge clk_i) begin
    if (srst_i) begin
      stat_q <= {`CSC_IRQ_W{1'b0}};
    end else if (ce_i) begin
      stat_q <= (stat_q & ~((wr_i && addr_i == `CSC_OFF_STAT) ? wdata_i[`CSC_IRQ_W-1:0] :
                {`CSC_IRQ_W{1'b0}})) | {run && seq_end, run && conv_hit};
    end
  end
  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= 16'h0000;
      irq_o <= 1'b0;
      sampling_o <= 1'b0;
      converting_o <= 1'b0;
      channel_o <= 2'h0;
      hold_o <= 4'h0;
    end else if (ce_i) begin
      irq_o <= |(stat_q & mask_q);
      sampling_o <= (state_q == ST_SAMPLE_CONTROL_BIT);
      converting_o <= (state_q == ST_CONV);
      channel_o <= ch_q;
      // simultaneous holds all selected channels; sequential only the current one
      if (state_q != ST_SAMPLE_CONTROL_BIT)
        hold_o <= 4'h0;
      else if (sim_q && multi)
        hold_o <= (chcnt_q == 2'h1) ? 4'h3 : 4'hF;
      else
        hold_o <= 4'h1 << ch_q;
      rdata_o <= 16'h0000;
      if (rd_i) begin
        case (addr_i)
          `CSC_OFF_CTRL1: rdata_o <= {enable_q, 7'h00, trig_q, 1'b0, sim_q, auto_q,
                                      sample_control_bit_q, done_q};
          `CSC_OFF_CTRL2: rdata_o <= {6'h00, chcnt_q, 8'h00};
          `CSC_OFF_CTRL3: rdata_o <= {3'h0, stime_q, 2'h0, cdiv_q};
          `CSC_OFF_STAT: rdata_o <= {14'h0000, stat_q};
          `CSC_OFF_MASK: rdata_o <= {14'h0000, mask_q};
          `CSC_OFF_SEQ: rdata_o <= seq_cnt_q;
          default: rdata_o <= 16'h0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/csc_regs.vh ====
// Purpose: constants for the clocked sample/convert sequencer
// Assumes: one 20 MHz clock, converter clock derived by a divider
// Notes: definitions only
`ifndef CSC_REGS_VH
`define CSC_REGS_VH
`define CSC_ADDR_W 4
`define CSC_OFF_CTRL1 4'h0
`define CSC_OFF_CTRL2 4'h1
`define CSC_OFF_CTRL3 4'h2
`define CSC_OFF_STAT 4'h3
`define CSC_OFF_MASK 4'h4
`define CSC_OFF_SEQ 4'h5
`define CSC_B_ENABLE 15
`define CSC_B_TRIG_HI 7
`define CSC_B_TRIG_LO 5
`define CSC_B_SIMSEL 3
`define CSC_B_AUTO 2
`define CSC_B_SAMPLE 1
`define CSC_B_DONE 0
`define CSC_B_CHCNT_HI 9
`define CSC_B_CHCNT_LO 8
`define CSC_B_STIME_HI 12
`define CSC_B_STIME_LO 8
`define CSC_B_CDIV_HI 5
`define CSC_B_CDIV_LO 0
`define CSC_TRIG_CLOCKED 3'h7
`define CSC_TRIG_MANUAL 3'h0
`define CSC_RST_CTRL 16'h0000
`define CSC_CONV_PERIODS 5'h0C
`define CSC_IRQ_W 2
`define CSC_IRQ_SEQ 1
`define CSC_IRQ_CONV 0
`endif

// ==== rtl/csc_tick_div.v ====
// Purpose: converter clock period strobe from the system clock
// Assumes: divisor field from software, period = (div+1) clocks
// Notes: restarts on clear so periods align to sequence start
`timescale 1ns/10ps
`default_nettype none
module csc_tick_div (
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  input wire clr_i,
  input wire [5:0] div_i,
  output reg tick_o
);
  reg [5:0] cnt_q;
  // strobe is combinational so a period ends on its own edge, not one clock late
  always @* begin
    tick_o = (cnt_q >= div_i);
  end
  // the clear does not feed the strobe, so no loop through the sequencer
  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= 6'h00;
    end else if (ce_i) begin
      if (clr_i || (cnt_q >= div_i))
        cnt_q <= 6'h00;
      else
        cnt_q <= cnt_q + 6'h01;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/csc_period_cnt.v ====
// Purpose: counts converter clock periods up to a target
// Assumes: tick_i one cycle per converter period
// Notes: hit_o pulses for one cycle when the count reaches the target
`timescale 1ns/10ps
`default_nettype none
module csc_period_cnt (
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  input wire start_i,
  input wire tick_i,
  input wire [4:0] target_i,
  output reg hit_o,
  output reg busy_o
);
  reg [4:0] cnt_q;
  reg zero_q;
  // hit is combinational so the phase ends on the edge of its last period
  always @* begin
    hit_o = ce_i && (zero_q || (busy_o && tick_i && ((cnt_q + 5'h01) >= target_i)));
  end
  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= 5'h00;
      zero_q <= 1'b0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      zero_q <= 1'b0;
      if (start_i) begin
        cnt_q <= 5'h00;
        // a zero target ends one cycle after start; only the sample counter can get one, as the conversion target is fixed at 12
        zero_q <= (target_i == 5'h00);
        busy_o <= (target_i != 5'h00);
      end else if (busy_o && tick_i) begin
        if ((cnt_q + 5'h01) >= target_i)
          busy_o <= 1'b0;
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/csc_chk.sv ====
// Purpose: port checker for the sample/convert sequencer
// Assumes: config written only while the block is disabled
// Notes: config mirrored from bus writes; disable acts as abort
`timescale 1ns/10ps
`default_nettype none
module csc_chk (
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire sampling_o,
  input wire converting_o,
  input wire [1:0] channel_o,
  input wire [3:0] hold_o
);
  logic [15:0] c1_q, c2_q, c3_q;
  logic [7:0] sample_control_bit_q, conv_q;
  logic [3:0] set_q;
  logic on, wr1;
  logic [1:0] chn;
  assign on = c1_q[15] && c1_q[7:5] == 3'h7;
  assign chn = c2_q[9:8];
  assign wr1 = wr_i && ce_i && addr_i == 4'h0;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      c1_q <= 16'h0000;
      c2_q <= 16'h0000;
      c3_q <= 16'h0000;
      sample_control_bit_q <= 8'h00;
      conv_q <= 8'h00;
      set_q <= 4'hF;
    end else begin
      if (wr1) c1_q <= wdata_i;
      if (wr_i && ce_i && addr_i == 4'h1) c2_q <= wdata_i;
      if (wr_i && ce_i && addr_i == 4'h2) c3_q <= wdata_i;
      sample_control_bit_q <= sampling_o ? sample_control_bit_q + 8'h01 : 8'h00;
      conv_q <= converting_o ? conv_q + 8'h01 : 8'h00;
      // saturate so an old write never looks recent
      set_q <= (wr1 && wdata_i[1]) ? 4'h0 : (set_q == 4'hF ? set_q : set_q + 4'h1);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_resume;
    ##[0:2] sampling_o;
  endsequence
  chk_phase_excl: assert property (!(sampling_o && converting_o))
    else $error("sample and convert overlap");
  chk_sample_control_bit_len: assert property ($fell(sampling_o) && on && c3_q[12:8] != 5'h00 |-> converting_o && sample_control_bit_q == c3_q[12:8] * (c3_q[5:0] + 6'h01))
    else $error("sample length wrong");
  chk_conv_len: assert property ($fell(converting_o) && on |-> conv_q % (8'h0C * (c3_q[5:0] + 6'h01)) == 8'h00)
    else $error("conversion length wrong");
  chk_manual_start: assert property ($rose(sampling_o) && !c1_q[2] && chn == 2'h0 |-> set_q <= 4'h4)
    else $error("sampling without request");
  chk_auto_resume: assert property ($fell(converting_o) && on && c1_q[2] |-> s_resume)
    else $error("auto sampling did not resume");
  chk_seq_hold: assert property (sampling_o && on && !c1_q[3] |-> hold_o == 4'h1 << channel_o)
    else $error("sequential hold wrong");
  chk_sim_hold: assert property (sampling_o && on && c1_q[3] && chn != 2'h0 |-> hold_o == (chn == 2'h1 ? 4'h3 : 4'hF))
    else $error("simultaneous hold wrong");
  chk_chan_range: assert property (converting_o && on |-> channel_o <= (chn == 2'h0 ? 2'h0 : (chn == 2'h1 ? 2'h1 : 2'h3)))
    else $error("channel out of range");
endmodule
bind csc_sequencer csc_chk u_chk (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .sampling_o(sampling_o), .converting_o(converting_o),
  .channel_o(channel_o), .hold_o(hold_o));
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: directed bench for the sample/convert sequencer
// Assumes: one 20 MHz clock, config written while disabled
// Notes: clock enable held high, so freeze behaviour is unexercised
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] d;
  wire [15:0] rdata_o;
  wire irq_o, sampling_o, converting_o;
  wire [1:0] channel_o;
  wire [3:0] hold_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int k;
  always #25 clk_i = ~clk_i;
  csc_sequencer u_csc_sequencer (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .sampling_o(sampling_o), .converting_o(converting_o), .channel_o(channel_o), .hold_o(hold_o));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task tick;
    @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // one sample phase then its conversion; es below zero skips the length
  task phase(input int es, input int ec, input logic [1:0] ch, input logic [3:0] h);
    int n;
    for (n = 0; n < 500 && sampling_o !== 1'b1; n++) tick;
    check({12'h000, hold_o}, {12'h000, h});
    for (n = 0; n < 500 && sampling_o === 1'b1; n++) tick;
    if (es >= 0) check(n[15:0], es[15:0]);
    check({14'h0000, channel_o}, {14'h0000, ch});
    for (n = 0; n < 500 && converting_o === 1'b1; n++) tick;
    check(n[15:0], ec[15:0]);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(4'h0);
    check(d, 16'h0000);
    rd(4'hF);
    check(d, 16'h0000);
    wr(4'h2, 16'h0301);
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h80E0);
    wr(4'h0, 16'h80E2);
    phase(6, 24, 2'h0, 4'h1);
    rd(4'h0);
    check(d, 16'h80E1);
    rd(4'h3);
    check(d, 16'h0003);
    rd(4'h5);
    check(d, 16'h0001);
    check({15'h0000, irq_o}, 16'h0000);
    wr(4'h4, 16'h0001);
    tick;
    tick;
    check({15'h0000, irq_o}, 16'h0001);
    wr(4'h3, 16'h0001);
    tick;
    tick;
    check({15'h0000, irq_o}, 16'h0000);
    repeat (40) tick;
    check({15'h0000, sampling_o}, 16'h0000);
    $display("test manual clocked done");
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0200);
    wr(4'h2, 16'h0200);
    wr(4'h0, 16'h80E4);
    for (k = 0; k < 8; k++) phase(2, 12, k[1:0], 4'h1 << k[1:0]);
    $display("test sequential four done");
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0100);
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'h80E4);
    for (k = 0; k < 4; k++) phase(-1, 12, {1'b0, k[0]}, 4'h1 << k[0]);
    $display("test zero sample time done");
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0200);
    wr(4'h2, 16'h0300);
    wr(4'h0, 16'h80EC);
    for (k = 0; k < 2; k++) phase(3, 48, 2'h0, 4'hF);
    $display("test simultaneous done");
    wr(4'h0, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h2, 16'h0100);
    wr(4'h0, 16'h80E4);
    for (k = 0; k < 2; k++) phase(1, 12, 2'h0, 4'h1);
    $display("test single auto done");
    report_and_stop;
  end
endmodule
`default_nettype wire
